//--- common/usb_flag_pkg.sv
// constants, types and register map of the host event flag block
// Function
// - stall handshake seen sets bit 7
// - non-SE0 without activity 2.5 us sets attach
// - K-state held 2.5 us sets resume
// - idle held 3 ms sets bit 4
// - token done sets bit 3, status stored
// - host frame count hits threshold sets bit 2
// - only enabled errors set bit 1
// - detach sets bit 0, once per reset
// - writing one clears, zero keeps flag
// - upper three bytes read zero, writes ignored
// - flags set by hardware only, reset zero
// - status holds endpoint, direction, bank bit
// - threshold counts 10 plus packet bytes
`default_nettype none
package usb_flag_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ERR_EN = 8'h0C;
    localparam logic [7:0] ADDR_THRESH = 8'h10;
    localparam int ADDR_W = 8;
    localparam int REG_W = 8;
    localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [REG_W-1:0] THRESH_RESET = 8'h00;

    // -------------------------------------------------------------
    // flag bit positions
    // -------------------------------------------------------------
    localparam int BIT_STALL = 7;
    localparam int BIT_ATTACH = 6;
    localparam int BIT_RESUME = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_TOKEN = 3;
    localparam int BIT_FRAME = 2;
    localparam int BIT_ERROR = 1;
    localparam int BIT_DETACH = 0;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 20;
    localparam int ATTACH_TIME_NS = 2500;
    localparam int RESUME_TIME_NS = 2500;
    localparam int IDLE_TIME_US = 3000;
    localparam int ATTACH_CYCLES = (ATTACH_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int RESUME_CYCLES = (RESUME_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_FREQ_MHZ;
    localparam int FRAME_BYTES = 1500;
    localparam logic [7:0] THRESH_OVERHEAD = 8'h0A;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [3:0] last_endpoint_num;
        logic dir_tx;
        logic bank_odd_even;
    } token_info_s;

    typedef struct packed {
        logic dp;
        logic dm;
    } line_s;

endpackage
`default_nettype wire

//--- rtl/line_hold_timer.sv
// counts how long a line condition has held and pulses once
`timescale 1ns/1ps
`default_nettype none
module line_hold_timer #(
    parameter int HOLD_CYCLES = 50
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cond_in,
    output logic hit_out
);
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(HOLD_CYCLES);

    logic [CNT_W-1:0] count;

    generate
        if (HOLD_CYCLES < 1) begin : g_bad
            $error("hold count must be at least one");
        end
    endgenerate

    // -------------------------------------------------------------
    // hold counter, restarts whenever the condition breaks
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in || !cond_in) begin
            count <= '0;
        end else if (count != LIMIT) begin
            count <= count + CNT_W'(1);
        end
    end

    // -------------------------------------------------------------
    // one pulse as the limit is reached
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hit_out <= 1'b0;
        end else begin
            hit_out <= cond_in && (count == LIMIT - CNT_W'(1));
        end
    end
endmodule
`default_nettype wire

//--- rtl/usb_host_event_flags.sv
// host event flag register with line-state detectors and apb slave
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usb_host_event_flags
    import usb_flag_pkg::*;
#(
    parameter int IDLE_HOLD_CYCLES = IDLE_CYCLES,
    parameter int ERR_W = 8,
    parameter int FRAME_LEN = FRAME_BYTES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire line_s line_in,
    input wire logic low_speed_in,
    input wire logic bus_activity_in,
    input wire logic host_mode_in,
    input wire logic bus_reset_in,
    input wire logic stall_hs_in,
    input wire logic token_done_in,
    input wire token_info_s token_info_in,
    input wire logic [ERR_W-1:0] error_events_in,
    input wire logic frame_start_in,
    input wire logic byte_tick_in,
    output logic irq_out
);
    localparam int FCNT_W = $clog2(FRAME_LEN + 1);

    generate
        if (ERR_W < 1 || ERR_W > REG_W || FRAME_LEN < 256) begin : g_bad
            $error("unsupported error width or frame length");
        end
    endgenerate

    logic [REG_W-1:0] flags;
    logic [REG_W-1:0] mask;
    logic [ERR_W-1:0] err_enable;
    logic [REG_W-1:0] threshold;
    token_info_s status;
    logic [REG_W-1:0] events;
    logic [FCNT_W-1:0] frame_left;
    logic detach_lock;
    logic reset_seen;
    logic se0;
    logic k_state;
    logic j_state;
    logic attach_hit;
    logic resume_hit;
    logic idle_hit;
    logic detach_hit;
    logic wr_acc;
    logic rd_acc;
    logic mapped;

    // -------------------------------------------------------------
    // address decode helper
    // -------------------------------------------------------------
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        if (a == ADDR_FLAGS) begin
            return 1'b1;
        end else if (a == ADDR_MASK) begin
            return 1'b1;
        end else if (a == ADDR_STATUS) begin
            return 1'b1;
        end else if (a == ADDR_ERR_EN) begin
            return 1'b1;
        end else if (a == ADDR_THRESH) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // -------------------------------------------------------------
    // line states
    // -------------------------------------------------------------
    assign se0 = !line_in.dp && !line_in.dm;
    // k is differential one at low speed, zero at full speed
    assign k_state = low_speed_in ? (line_in.dp && !line_in.dm)
                                  : (!line_in.dp && line_in.dm);
    assign j_state = low_speed_in ? (!line_in.dp && line_in.dm)
                                  : (line_in.dp && !line_in.dm);

    line_hold_timer #(.HOLD_CYCLES(ATTACH_CYCLES)) u_attach (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cond_in(!se0 && !bus_activity_in),
        .hit_out(attach_hit)
    );

    line_hold_timer #(.HOLD_CYCLES(RESUME_CYCLES)) u_resume (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cond_in(k_state),
        .hit_out(resume_hit)
    );

    line_hold_timer #(.HOLD_CYCLES(IDLE_HOLD_CYCLES)) u_idle (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cond_in(j_state && !bus_activity_in),
        .hit_out(idle_hit)
    );

    line_hold_timer #(.HOLD_CYCLES(ATTACH_CYCLES)) u_detach (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cond_in(se0),
        .hit_out(detach_hit)
    );

    // -------------------------------------------------------------
    // detach lock, released once bus reset has come and gone
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            detach_lock <= 1'b0;
            reset_seen <= 1'b0;
        end else if (detach_hit && !detach_lock) begin
            detach_lock <= 1'b1;
            reset_seen <= 1'b0;
        end else if (detach_lock && bus_reset_in) begin
            reset_seen <= 1'b1;
        end else if (detach_lock && reset_seen) begin
            detach_lock <= 1'b0;
            reset_seen <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // host frame byte counter
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frame_left <= '0;
        end else if (frame_start_in) begin
            frame_left <= FCNT_W'(FRAME_LEN);
        end else if (byte_tick_in && frame_left != '0) begin
            frame_left <= frame_left - FCNT_W'(1);
        end
    end

    // -------------------------------------------------------------
    // event vector
    // -------------------------------------------------------------
    always_comb begin
        events = '0;
        events[BIT_STALL] = stall_hs_in;
        events[BIT_ATTACH] = attach_hit;
        events[BIT_RESUME] = resume_hit;
        events[BIT_IDLE] = idle_hit;
        events[BIT_TOKEN] = token_done_in;
        // threshold already holds 10 plus packet bytes
        events[BIT_FRAME] = host_mode_in && byte_tick_in
            && (frame_left == FCNT_W'(threshold));
        events[BIT_ERROR] = |(error_events_in & err_enable);
        events[BIT_DETACH] = detach_hit && !detach_lock;
    end

    // -------------------------------------------------------------
    // apb access
    // -------------------------------------------------------------
    assign mapped = is_mapped(paddr_in);
    assign wr_acc = psel_in && penable_in && pwrite_in && mapped;
    assign rd_acc = psel_in && penable_in && !pwrite_in && mapped;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // -------------------------------------------------------------
    // flag register: set wins over write-one clear
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags <= FLAGS_RESET;
        end else if (wr_acc && paddr_in == ADDR_FLAGS && pstrb_in[0]) begin
            // upper bits of the write are dropped
            flags <= (flags & ~pwdata_in[REG_W-1:0]) | events;
        end else begin
            flags <= flags | events;
        end
    end

    // -------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask <= '0;
            err_enable <= '0;
            threshold <= THRESH_RESET;
        end else if (wr_acc && pstrb_in[0]) begin
            if (paddr_in == ADDR_MASK) begin
                mask <= pwdata_in[REG_W-1:0];
            end else if (paddr_in == ADDR_ERR_EN) begin
                err_enable <= pwdata_in[ERR_W-1:0];
            end else if (paddr_in == ADDR_THRESH) begin
                threshold <= pwdata_in[REG_W-1:0];
            end
        end
    end

    // -------------------------------------------------------------
    // transfer status capture
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status <= '0;
        end else if (token_done_in) begin
            status <= token_info_in;
        end
    end

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= '0;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            if (paddr_in == ADDR_FLAGS) begin
                prdata_out <= {24'h000000, flags};
            end else if (paddr_in == ADDR_MASK) begin
                prdata_out <= {24'h000000, mask};
            end else if (paddr_in == ADDR_STATUS) begin
                prdata_out <= {24'h000000, status, 2'h0};
            end else if (paddr_in == ADDR_ERR_EN) begin
                prdata_out <= 32'(err_enable);
            end else if (paddr_in == ADDR_THRESH) begin
                prdata_out <= {24'h000000, threshold};
            end else begin
                prdata_out <= '0;
            end
        end
    end

    // -------------------------------------------------------------
    // interrupt line
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(flags & mask);
        end
    end

    logic unused_rd;
    assign unused_rd = rd_acc;
endmodule
`default_nettype wire

//--- tb/usb_host_event_flags_chk.sv
// port assertions of the host event flag block
`timescale 1ns/1ps
`default_nettype none
module usb_host_event_flags_chk
    import usb_flag_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire logic stall_hs_in,
    input wire logic token_done_in,
    input wire token_info_s token_info_in,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic acc;
    logic rd;
    logic fwr;
    logic mapped;
    logic stall_p;
    logic tok_p;
    token_info_s info;
    logic [7:0] thr;
    assign acc = psel_in && penable_in;
    assign rd = acc && !pwrite_in;
    assign fwr = acc && pwrite_in && pstrb_in[0] && paddr_in == ADDR_FLAGS;
    assign mapped = paddr_in inside {ADDR_FLAGS, ADDR_MASK, ADDR_STATUS,
        ADDR_ERR_EN, ADDR_THRESH};
    // shadows of sticky flags and stored values
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stall_p <= 1'b0;
            tok_p <= 1'b0;
            info <= '0;
            thr <= 8'h00;
        end else begin
            stall_p <= stall_hs_in || (stall_p && !(fwr && pwdata_in[7]));
            tok_p <= token_done_in || (tok_p && !(fwr && pwdata_in[3]));
            if (token_done_in)
                info <= token_info_in;
            if (acc && pwrite_in && pstrb_in[0] && paddr_in == ADDR_THRESH)
                thr <= pwdata_in[7:0];
        end
    end
    a_upper_zero: assert property (
        rd |-> prdata_out[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_unmapped_err: assert property (
        acc && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        acc && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_stall_sticky: assert property (
        rd && paddr_in == ADDR_FLAGS && $past(stall_p) && $past(stall_p, 2)
        |-> prdata_out[BIT_STALL])
        else $error("stall flag lost");
    a_token_sticky: assert property (
        rd && paddr_in == ADDR_FLAGS && $past(tok_p) && $past(tok_p, 2)
        |-> prdata_out[BIT_TOKEN])
        else $error("token flag lost");
    a_status_info: assert property (
        rd && paddr_in == ADDR_STATUS && !$past(token_done_in)
        && !$past(token_done_in, 2) |-> prdata_out[7:0] == {info, 2'b00})
        else $error("status does not match token");
    a_thresh_back: assert property (
        rd && paddr_in == ADDR_THRESH |-> prdata_out[7:0] == $past(thr))
        else $error("threshold readback wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_in |=> !irq_out && prdata_out == 32'h00000000)
        else $error("outputs not cleared by reset");
    c_stall: cover property (stall_hs_in);
    c_clear: cover property (fwr);
    c_unmapped: cover property (acc && !mapped);
endmodule
bind usb_host_event_flags usb_host_event_flags_chk
    usb_host_event_flags_chk_inst (
    .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pslverr_out, .stall_hs_in,
    .token_done_in, .token_info_in, .irq_out);
`default_nettype wire

//--- tb/usb_host_event_flags_tb.sv
// self-checking bench of the host event flag block
`timescale 1ns/1ps
`default_nettype none
module usb_host_event_flags_tb
    import usb_flag_pkg::*;
;
    localparam int IDLE_SIM = 200;
    logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [ADDR_W-1:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out;
    logic [3:0] pstrb_in = '0;
    logic [3:0] strb = 4'hF;
    logic pready_out, pslverr_out, irq_out, bus_activity_in;
    line_s line_in;
    logic [1:0] mode = 2'd3;
    logic low_speed_in = 0, host_mode_in = 0, bus_reset_in = 0;
    logic stall_hs_in = 0, token_done_in = 0, frame_start_in = 0;
    logic byte_tick_in = 0;
    token_info_s token_info_in = '0, info;
    logic [7:0] error_events_in = '0, e;
    int num_errors = 0, checked = 0, cyc = 0;
    logic [31:0] exp_q[$];
    string name_q[$];
    usb_periph_model usb_periph_model_inst (.clk_in, .mode_in(mode),
        .low_speed_in, .line_out(line_in), .act_out(bus_activity_in));
    usb_host_event_flags #(.IDLE_HOLD_CYCLES(IDLE_SIM))
        usb_host_event_flags_inst (.clk_in, .rst_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
        .pready_out, .pslverr_out, .line_in, .low_speed_in,
        .bus_activity_in, .host_mode_in, .bus_reset_in, .stall_hs_in,
        .token_done_in, .token_info_in, .error_events_in, .frame_start_in,
        .byte_tick_in, .irq_out);
    always #25 clk_in = ~clk_in;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] x,
        input logic [31:0] s);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1;
        pwrite_in <= wr_en;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= strb;
        @(posedge clk_in);
        penable_in <= 1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 0;
        penable_in <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input string n);
        exp_q.push_back(x);
        name_q.push_back(n);
        apb(0, a, 32'h0);
    endtask
    task automatic ev(input logic s, input logic t, input logic [7:0] er);
        stall_hs_in <= s;
        token_done_in <= t;
        error_events_in <= er;
        w(1);
        stall_hs_in <= 0;
        token_done_in <= 0;
        error_events_in <= 0;
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    // ---------------------------------------------------------------
    // monitor and timeout
    // ---------------------------------------------------------------
    always @(posedge clk_in) begin
        if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1)
            cmp(name_q.pop_front(), exp_q.pop_front(), prdata_out);
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(88));
        w(4);
        rst_in <= 0;
        rd(ADDR_FLAGS, 0, "flags");
        rd(ADDR_THRESH, 0, "thresh");
        rd(8'h40, 0, "unmapped");
        wr(ADDR_FLAGS, 32'hFFFFFF00);
        rd(ADDR_FLAGS, 0, "flags");
        tdone("reset");
        wr(ADDR_MASK, 32'h80);
        rd(ADDR_MASK, 32'h80, "mask");
        ev(1, 0, 0);
        w(3);
        #1 cmp("irq", 1, irq_out);
        wr(ADDR_FLAGS, $urandom & 32'h7F);
        strb = 4'hE;
        wr(ADDR_FLAGS, 32'h80);
        strb = 4'hF;
        rd(ADDR_FLAGS, 32'h80, "flags");
        wr(ADDR_FLAGS, 32'h80);
        rd(ADDR_FLAGS, 0, "flags");
        w(2);
        #1 cmp("irq", 0, irq_out);
        tdone("stall");
        info = $urandom;
        token_info_in <= info;
        ev(0, 1, 0);
        rd(ADDR_FLAGS, 32'h08, "flags");
        rd(ADDR_STATUS, {24'h0, info, 2'b00}, "status");
        wr(ADDR_FLAGS, 32'hFF);
        e = 8'h01 << ($urandom % 8);
        wr(ADDR_ERR_EN, {24'h0, e});
        rd(ADDR_ERR_EN, {24'h0, e}, "err_en");
        ev(0, 0, ~e);
        rd(ADDR_FLAGS, 0, "flags");
        ev(0, 0, e);
        rd(ADDR_FLAGS, 32'h02, "flags");
        wr(ADDR_FLAGS, 32'hFF);
        tdone("token error");
        for (int ls = 0; ls < 2; ls++) begin
            low_speed_in <= ls[0];
            mode <= 0;
            w(60);
            rd(ADDR_FLAGS, 32'h40, "flags");
            mode <= 1;
            w(60);
            rd(ADDR_FLAGS, 32'h60, "flags");
            mode <= 3;
            wr(ADDR_FLAGS, 32'hFF);
        end
        mode <= 0;
        w(IDLE_SIM + 20);
        rd(ADDR_FLAGS, 32'h50, "flags");
        mode <= 3;
        wr(ADDR_FLAGS, 32'hFF);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                bus_reset_in <= 1;
                w(5);
                bus_reset_in <= 0;
                w(2);
            end
            mode <= 2;
            w(60);
            rd(ADDR_FLAGS, (i == 1) ? 32'h0 : 32'h1, "flags");
            mode <= 3;
            wr(ADDR_FLAGS, 32'hFF);
            w(5);
        end
        tdone("lines");
        wr(ADDR_THRESH, 32'h4A);
        for (int hm = 1; hm >= 0; hm--) begin
            host_mode_in <= hm[0];
            frame_start_in <= 1;
            w(1);
            frame_start_in <= 0;
            repeat (FRAME_BYTES) begin
                byte_tick_in <= 1;
                w(1);
                byte_tick_in <= 0;
                w(1);
            end
            rd(ADDR_FLAGS, hm ? 32'h4 : 32'h0, "flags");
            wr(ADDR_FLAGS, 32'hFF);
        end
        rd(ADDR_THRESH, 32'h4A, "thresh");
        tdone("frame");
        w(3);
        print_verdict;
    end
endmodule
`default_nettype wire

//--- tb/usb_periph_model.sv
// usb peripheral model driving the host port lines
`timescale 1ns/1ps
`default_nettype none
module usb_periph_model
    import usb_flag_pkg::*;
(
    input wire logic clk_in,
    input wire logic [1:0] mode_in,
    input wire logic low_speed_in,
    output line_s line_out,
    output logic act_out
);
    // modes: 0 idle J, 1 K, 2 SE0, 3 traffic
    initial line_out = 2'b10;
    always @(posedge clk_in) begin
        act_out <= (mode_in == 2'd3);
        case (mode_in)
            2'd0: line_out <= low_speed_in ? 2'b01 : 2'b10;
            2'd1: line_out <= low_speed_in ? 2'b10 : 2'b01;
            2'd2: line_out <= 2'b00;
            default: line_out <= (line_out == 2'b10) ? 2'b01 : 2'b10;
        endcase
    end
endmodule
`default_nettype wire
